// ==== btr_cfg.svh ====
// constants for the branch trace recorder: offsets, fields, reset values
`ifndef BTR_CFG_SVH
`define BTR_CFG_SVH
`define BTR_REC_BASE        12'h040
`define BTR_REC_LAST        12'h047
`define BTR_TOP_ADDR        12'h1C9
`define BTR_CTL_ADDR        12'h1D9
`define BTR_LER_TO_ADDR     12'h1DD
`define BTR_LER_FROM_ADDR   12'h1DE
`define BTR_STAT_ADDR       12'h1E0
`define BTR_DSCFG_ADDR      12'h1E1
`define BTR_HCMD_ADDR       4'h0
`define BTR_HSTAT_ADDR      4'h1
`define BTR_HIDX_ADDR       4'h2
`define BTR_HEVT_ADDR       4'h3
`define BTR_BIT_REC         0
`define BTR_BIT_STEP        1
`define BTR_BIT_PIN_LO      2
`define BTR_BIT_MSG         6
`define BTR_BIT_STORE       7
`define BTR_BIT_IRQ         8
`define BTR_CTL_RESET       9'h000
`define BTR_DS_RESET        16'h0000
`define BTR_PIN_PULSE       2'h2
`endif

// ==== btr_pkg.sv ====
// types for the branch trace recorder: event kinds used by the core, handler states used by the controller
package btr_pkg;
  typedef enum logic [1:0] {
    BTR_EV_BRANCH = 2'b00,
    BTR_EV_INTR   = 2'b01,
    BTR_EV_EXCP   = 2'b10,
    BTR_EV_DEBUG  = 2'b11
  } btr_event_t;
  typedef enum logic [1:0] {
    BTR_H_IDLE  = 2'b00,
    BTR_H_QUIET = 2'b01,
    BTR_H_DRAIN = 2'b10,
    BTR_H_DONE  = 2'b11
  } btr_hstate_t;
endpackage : btr_pkg

// ==== btr_if.sv ====
// link between the recording core logic and the servicing controller
`timescale 1ns/100ps
interface btr_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata;
  logic [63:0] reg_rdata;
  logic        ds_irq;
  logic        irq_masked;
  logic        counter_overflow;
  logic        unmask;
  logic        sampling_enable;
  modport core (input reg_wr, reg_rd, reg_addr, reg_wdata, unmask,
                input sampling_enable,
                output reg_rdata, ds_irq, irq_masked, counter_overflow);
  modport ctrl (output reg_wr, reg_rd, reg_addr, reg_wdata, unmask,
                output sampling_enable,
                input reg_rdata, ds_irq, irq_masked, counter_overflow);
endinterface : btr_if

// ==== btr_core.sv ====
// branch recording, stepping, pins, trace messages and trace store
`timescale 1ns/100ps
`include "btr_cfg.svh"
module btr_core (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // pipeline events
  input  wire logic        event_valid_i,
  input  wire logic [1:0]  event_kind_i,
  input  wire logic [31:0] event_source_i,
  input  wire logic [31:0] event_target_i,
  input  wire logic        trap_flag_i,
  input  wire logic        instr_retire_i,
  input  wire logic [3:0]  bp_match_i,
  input  wire logic [3:0]  perf_event_i,
  input  wire logic        counter_overflow_i,
  // observed outputs
  output logic             step_trap_o,
  output logic [3:0]       breakpoint_pin_out_n_o,
  output logic             branch_message_valid_o,
  output logic [63:0]      branch_message_o,
  output logic             store_write_o,
  output logic [15:0]      store_index_o,
  output logic [63:0]      store_data_o,
  // link to controller
  btr_if.core              link
);
  typedef struct packed {
    logic [8:0]       ctl;
    logic [7:0][63:0] rec;
    logic [2:0]       top;
    logic [31:0]      ler_to;
    logic [31:0]      ler_from;
    logic [31:0]      last_to;
    logic [31:0]      last_from;
    logic [15:0]      idx;
    logic [15:0]      thresh;
    logic [15:0]      absmax;
    logic             ds_on;
    logic             pend;
    logic             masked;
    logic             ovf;
    logic [3:0][1:0]  pin_cnt;
    logic [63:0]      rdata;
    logic             step;
    logic             msg_v;
    logic [63:0]      msg;
    logic             st_w;
    logic [15:0]      st_idx;
  } btr_core_t;

  btr_core_t r;
  btr_core_t next_r;
  logic      rec_now;
  logic      dbg_ev;
  logic      pend_set;
  logic [63:0] entry;

  assign dbg_ev  = event_valid_i &&
                   (event_kind_i == btr_pkg::BTR_EV_DEBUG);
  assign rec_now = event_valid_i && !dbg_ev;
  assign entry   = {event_target_i, event_source_i};

  always_comb
  begin
    next_r = r;
    next_r.step  = 1'b0;
    next_r.msg_v = 1'b0;
    next_r.st_w  = 1'b0;
    pend_set     = 1'b0;
    if (link.reg_wr)
    begin
      case (link.reg_addr)
        `BTR_CTL_ADDR: next_r.ctl = link.reg_wdata[8:0];
        `BTR_DSCFG_ADDR:
        begin
          next_r.idx    = link.reg_wdata[15:0];
          next_r.thresh = link.reg_wdata[31:16];
          next_r.absmax = link.reg_wdata[47:32];
          // programming the area enables it; the command port has no off
          next_r.ds_on  = 1'b1;
        end
        default: next_r.ctl = r.ctl;
      endcase
    end
    if (rec_now && r.ctl[`BTR_BIT_REC])
    begin
      next_r.top = r.top + 3'h1;
      next_r.rec[r.top + 3'h1] = entry;
      if (event_kind_i != btr_pkg::BTR_EV_BRANCH)
      begin
        next_r.ler_to   = r.last_to;
        next_r.ler_from = r.last_from;
      end
      else
      begin
        next_r.last_to   = event_target_i;
        next_r.last_from = event_source_i;
      end
    end
    if (rec_now && r.ctl[`BTR_BIT_MSG])
    begin
      if (!r.ctl[`BTR_BIT_STORE])
      begin
        next_r.msg_v = 1'b1;
        next_r.msg   = entry;
      end
      else if (r.ds_on)
      begin
        next_r.st_w   = 1'b1;
        next_r.st_idx = r.idx;
        next_r.msg    = entry;
        if (r.idx + 16'h0001 >= r.absmax && !r.ctl[`BTR_BIT_IRQ])
          next_r.idx = 16'h0000;
        else if (r.idx < r.absmax)
          next_r.idx = r.idx + 16'h0001;
        if (r.ctl[`BTR_BIT_IRQ] && (r.idx + 16'h0001 >= r.thresh))
        begin
          next_r.pend = 1'b1;
          pend_set    = 1'b1;
        end
      end
    end
    if (counter_overflow_i)
      next_r.ovf = 1'b1;
    if ((next_r.pend || next_r.ovf) && !r.masked)
      next_r.masked = 1'b1;
    else if (link.unmask)
    begin
      next_r.masked = 1'b0;
      // a new threshold hit in the unmask cycle must survive
      next_r.pend   = pend_set;
      next_r.ovf    = counter_overflow_i;
    end
    if (dbg_ev)
      next_r.ctl[`BTR_BIT_REC] = 1'b0;
    if (trap_flag_i)
      next_r.step = r.ctl[`BTR_BIT_STEP] ? rec_now : instr_retire_i;
    for (int i = 0; i < 4; i++)
    begin
      if (r.pin_cnt[i] != 2'h0)
        next_r.pin_cnt[i] = r.pin_cnt[i] - 2'h1;
      else if (bp_match_i[i] && r.ctl[`BTR_BIT_PIN_LO + i])
        next_r.pin_cnt[i] = `BTR_PIN_PULSE;
    end
    next_r.rdata = 64'h0000_0000_0000_0000;
    if (link.reg_rd)
    begin
      if (link.reg_addr >= `BTR_REC_BASE && link.reg_addr <= `BTR_REC_LAST)
        next_r.rdata = r.rec[link.reg_addr[2:0]];
      else
      begin
        case (link.reg_addr)
          `BTR_TOP_ADDR: next_r.rdata = {61'h0, r.top};
          `BTR_CTL_ADDR: next_r.rdata = {55'h0, r.ctl};
          `BTR_LER_TO_ADDR: next_r.rdata = {32'h0, r.ler_to};
          `BTR_LER_FROM_ADDR: next_r.rdata = {32'h0, r.ler_from};
          `BTR_STAT_ADDR:
            next_r.rdata = {45'h0, r.masked, r.ovf, r.pend, r.idx};
          `BTR_DSCFG_ADDR:
            next_r.rdata = {15'h0, r.ds_on, r.absmax, r.thresh, r.idx};
          default: next_r.rdata = 64'h0000_0000_0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r       <= '0;
      r.ctl   <= `BTR_CTL_RESET;
      r.idx   <= `BTR_DS_RESET;
    end
    else if (clk_en_i)
      r <= next_r;
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      breakpoint_pin_out_n_o[i] = r.ctl[`BTR_BIT_PIN_LO + i] ?
        (r.pin_cnt[i] == 2'h0) : !perf_event_i[i];
  end

  assign step_trap_o            = r.step;
  assign branch_message_valid_o = r.msg_v;
  assign branch_message_o       = r.msg;
  assign store_write_o          = r.st_w;
  assign store_index_o          = r.st_idx;
  assign store_data_o           = r.msg;
  assign link.reg_rdata         = r.rdata;
  assign link.ds_irq            = r.masked;
  assign link.irq_masked        = r.masked;
  assign link.counter_overflow  = r.ovf;
endmodule : btr_core

// ==== btr_ctrl.sv ====
// servicing controller that answers the shared debug-store interrupt
`timescale 1ns/100ps
`include "btr_cfg.svh"
module btr_ctrl (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // software port
  input  wire logic [3:0]  sw_addr_i,
  input  wire logic [63:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [63:0]      sw_rdata_o,
  // link to core
  btr_if.ctrl              link
);
  typedef struct packed {
    btr_pkg::btr_hstate_t st;
    logic [2:0]           step;
    logic [8:0]           saved_ctl;
    logic                 sampling;
    logic                 saved_smp;
    logic [15:0]          drained;
    logic [1:0]           cause;
    logic [7:0]           events;
    logic                 wr;
    logic                 rd;
    logic [11:0]          addr;
    logic [63:0]          wdata;
    logic                 unmask;
    logic [63:0]          rdata;
  } btr_ctrl_t;

  btr_ctrl_t r;
  btr_ctrl_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.wr     = 1'b0;
    next_r.rd     = 1'b0;
    next_r.unmask = 1'b0;
    next_r.rdata  = 64'h0000_0000_0000_0000;
    if (sw_rd_i)
    begin
      case (sw_addr_i)
        `BTR_HSTAT_ADDR: next_r.rdata = {60'h0, r.cause, r.st};
        `BTR_HIDX_ADDR:  next_r.rdata = {48'h0, r.drained};
        `BTR_HEVT_ADDR:  next_r.rdata = {56'h0, r.events};
        default:         next_r.rdata = 64'h0000_0000_0000_0000;
      endcase
    end
    if (sw_wr_i && sw_addr_i == `BTR_HCMD_ADDR && r.st == btr_pkg::BTR_H_IDLE)
    begin
      next_r.wr       = 1'b1;
      next_r.addr     = sw_wdata_i[59:48];
      next_r.wdata    = {16'h0, sw_wdata_i[47:0]};
      next_r.sampling = sw_wdata_i[63];
    end
    case (r.st)
      btr_pkg::BTR_H_IDLE:
        // mask still shows high in the unmask cycle: no re-entry then
        if (link.ds_irq && !r.unmask && !next_r.wr)
        begin
          next_r.st   = btr_pkg::BTR_H_QUIET;
          next_r.step = 3'h0;
          next_r.rd   = 1'b1;
          next_r.addr = `BTR_CTL_ADDR;
        end
      btr_pkg::BTR_H_QUIET:
      begin
        next_r.step = r.step + 3'h1;
        if (r.step == 3'h0)
        begin
          next_r.rd   = 1'b1;
          next_r.addr = `BTR_STAT_ADDR;
        end
        else if (r.step == 3'h1)
        begin
          next_r.saved_ctl = link.reg_rdata[8:0];
          next_r.saved_smp = r.sampling;
          next_r.wr    = 1'b1;
          next_r.addr  = `BTR_CTL_ADDR;
          next_r.wdata = {55'h0, link.reg_rdata[8:7], 1'b0,
                          link.reg_rdata[5:0]};
          next_r.sampling = 1'b0;
        end
        else
        begin
          next_r.cause = {link.reg_rdata[17], link.reg_rdata[16]};
          next_r.drained = link.reg_rdata[15:0];
          next_r.st = btr_pkg::BTR_H_DRAIN;
        end
      end
      btr_pkg::BTR_H_DRAIN:
      begin
        if (r.cause[0])
        begin
          next_r.wr    = 1'b1;
          next_r.addr  = `BTR_DSCFG_ADDR;
          next_r.wdata = 64'h0001_FFFF_FFFF_0000;
        end
        next_r.events = r.events + 8'h01;
        next_r.st = btr_pkg::BTR_H_DONE;
      end
      btr_pkg::BTR_H_DONE:
      begin
        next_r.wr       = 1'b1;
        next_r.addr     = `BTR_CTL_ADDR;
        next_r.wdata    = {55'h0, r.saved_ctl};
        next_r.sampling = r.cause[1] | r.saved_smp;
        next_r.unmask   = 1'b1;
        next_r.st       = btr_pkg::BTR_H_IDLE;
      end
      default: next_r.st = btr_pkg::BTR_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      r <= '0;
    else if (clk_en_i)
      r <= next_r;
  end

  assign link.reg_wr          = r.wr;
  assign link.reg_rd          = r.rd;
  assign link.reg_addr        = r.addr;
  assign link.reg_wdata       = r.wdata;
  assign link.unmask          = r.unmask;
  assign link.sampling_enable = r.sampling;
  assign sw_rdata_o           = r.rdata;
endmodule : btr_ctrl

// ==== btr_checker.sv ====
// concurrent checks on the link between core and controller
`timescale 1ns/100ps
`include "btr_cfg.svh"
module btr_checker (
  // clock and reset
  input logic        sys_clk_i,
  input logic        reset_n_i,
  // link signals
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [11:0] reg_addr,
  input logic [63:0] reg_wdata,
  input logic [63:0] reg_rdata,
  input logic        ds_irq,
  input logic        irq_masked,
  input logic        unmask,
  input logic        sampling_enable
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  irq_level_a : assert property (ds_irq == irq_masked)
    else $error("interrupt differs from mask state");
  mask_hold_a : assert property (irq_masked && !unmask |=> irq_masked)
    else $error("mask dropped without unmask");
  ctl_save_a : assert property ($rose(ds_irq) |=>
    reg_rd && reg_addr == `BTR_CTL_ADDR)
    else $error("handler did not save control first");
  cause_read_a : assert property ($rose(ds_irq) |-> ##2
    reg_rd && reg_addr == `BTR_STAT_ADDR)
    else $error("handler did not read the cause");
  quiet_write_a : assert property ($rose(ds_irq) |-> ##3
    reg_wr && reg_addr == `BTR_CTL_ADDR && !reg_wdata[6])
    else $error("messages not quieted on entry");
  rewind_idx_a : assert property ($rose(ds_irq) ##3 reg_rdata[16] |-> ##2
    reg_wr && reg_addr == `BTR_DSCFG_ADDR && reg_wdata[15:0] == 16'h0)
    else $error("buffer index not rewound");
  quiet_sampling_a : assert property ($rose(ds_irq) |-> ##3
    !sampling_enable)
    else $error("sampling not quieted on entry");
  sampling_back_a : assert property ($rose(ds_irq) ##3 reg_rdata[17]
    |-> ##3 sampling_enable)
    else $error("counter not re-enabled after overflow");
  single_entry_a : assert property (unmask |=> !reg_rd)
    else $error("handler re-entered right after unmask");
  restore_ctl_a : assert property ($rose(ds_irq) |-> ##6
    reg_wr && reg_addr == `BTR_CTL_ADDR &&
    reg_wdata[8:0] == $past(reg_rdata[8:0], 4))
    else $error("control not restored on exit");
  unmask_exit_a : assert property ($rose(ds_irq) |-> ##6 unmask)
    else $error("mask not cleared on exit");
endmodule : btr_checker

// ==== btr_tb.sv ====
// self-checking bench joining core and controller over the link
`timescale 1ns/100ps
`include "btr_cfg.svh"
module btr_tb;
  logic        sys_clk_i;
  logic        reset_n_i;
  logic        ev_valid, trap_flag, retire, overflow, sw_wr, sw_rd;
  logic        step, msg_v, st_wr;
  logic [1:0]  ev_kind;
  logic [31:0] ev_src, ev_tgt;
  logic [3:0]  bp_match, perf_event, pin_n, sw_addr;
  logic [15:0] st_idx;
  logic [63:0] sw_wdata, sw_rdata, msg, sdata, rd;
  int          fail_count, samples_checked, cycles, steps, low0;

  btr_if u_btr_if ();
  btr_core u_btr_core (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(1'b1), .event_valid_i(ev_valid), .event_kind_i(ev_kind),
    .event_source_i(ev_src), .event_target_i(ev_tgt),
    .trap_flag_i(trap_flag), .instr_retire_i(retire),
    .bp_match_i(bp_match), .perf_event_i(perf_event),
    .counter_overflow_i(overflow), .step_trap_o(step),
    .breakpoint_pin_out_n_o(pin_n), .branch_message_valid_o(msg_v),
    .branch_message_o(msg), .store_write_o(st_wr),
    .store_index_o(st_idx), .store_data_o(sdata), .link(u_btr_if));
  btr_ctrl u_btr_ctrl (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(1'b1), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
    .link(u_btr_if));
  btr_checker u_btr_checker (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .reg_wr(u_btr_if.reg_wr),
    .reg_rd(u_btr_if.reg_rd), .reg_addr(u_btr_if.reg_addr),
    .reg_wdata(u_btr_if.reg_wdata), .reg_rdata(u_btr_if.reg_rdata),
    .ds_irq(u_btr_if.ds_irq), .irq_masked(u_btr_if.irq_masked),
    .unmask(u_btr_if.unmask),
    .sampling_enable(u_btr_if.sampling_enable));

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic sw_write(input logic [3:0] a, input logic [63:0] d);
    @(posedge sys_clk_i);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge sys_clk_i);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [3:0] a);
    @(posedge sys_clk_i);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge sys_clk_i);
    sw_rd <= 1'b0;
    #1 rd = sw_rdata;
  endtask : sw_read

  // core writes go through the command register, then settle
  task automatic core_wr(input logic [11:0] a, input logic [47:0] d);
    sw_write(4'h0, {4'h0, a, d});
    repeat (4) @(posedge sys_clk_i);
  endtask : core_wr

  task automatic ev(input logic [1:0] k, input logic [31:0] s,
                    input logic [31:0] t);
    @(posedge sys_clk_i);
    ev_valid <= 1'b1;
    ev_kind  <= k;
    ev_src   <= s;
    ev_tgt   <= t;
    @(posedge sys_clk_i);
    ev_valid <= 1'b0;
    #1;
  endtask : ev

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // watchdog plus pulse counters for step traps and pin 0
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    steps  <= steps + int'(step);
    low0   <= low0 + int'(!pin_n[0]);
    if (cycles == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    {ev_valid, trap_flag, retire, overflow, sw_wr, sw_rd} = '0;
    ev_kind = '0; ev_src = '0; ev_tgt = '0; bp_match = '0;
    perf_event = '0; sw_addr = '0; sw_wdata = '0; reset_n_i = 1'b0;
    fail_count = 0; samples_checked = 0; cycles = 0; steps = 0; low0 = 0;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1 check(pin_n, 4'hF);
    core_wr(`BTR_CTL_ADDR, 48'h0000_0000_0041);
    for (int k = 0; k < 3; k++)
    begin
      ev(k[1:0], 32'h1000_0000 + k, 32'h2000_0000 + k);
      check(msg_v, 1'b1);
      check(msg, {32'h2000_0000 + k, 32'h1000_0000 + k});
    end
    // threshold 2 of 4: interrupt after the second record
    core_wr(`BTR_DSCFG_ADDR, 48'h0004_0002_0000);
    core_wr(`BTR_CTL_ADDR, 48'h0000_0000_01C1);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        repeat (12) @(posedge sys_clk_i);
      ev(2'h0, 32'h3000_0000 + k, 32'h4000_0000 + k);
      check(msg_v, 1'b0);
      check(st_wr, 1'b1);
      check(st_idx, (k == 2) ? 16'h0 : k[15:0]);
      check(sdata, {32'h4000_0000 + k, 32'h3000_0000 + k});
    end
    sw_read(4'h3);
    check(rd, 64'h1);
    sw_read(4'h2);
    check(rd, 64'h2);
    core_wr(`BTR_DSCFG_ADDR, 48'h0002_FFFF_0000);
    core_wr(`BTR_CTL_ADDR, 48'h0000_0000_00C0);
    for (int k = 0; k < 3; k++)
    begin
      ev(2'h1, 32'h5000_0000, 32'h6000_0000);
      check(st_idx, {15'h0, k[0]});
    end
    @(posedge sys_clk_i);
    overflow <= 1'b1;
    @(posedge sys_clk_i);
    overflow <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    sw_read(4'h3);
    check(rd, 64'h2);
    core_wr(`BTR_CTL_ADDR, 48'h0000_0000_0002);
    trap_flag <= 1'b1;
    @(posedge sys_clk_i);
    retire <= 1'b1;
    @(posedge sys_clk_i);
    retire <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    check(steps, 0);
    ev(2'h2, 32'h7000_0000, 32'h8000_0000);
    repeat (4) @(posedge sys_clk_i);
    check(steps, 1);
    // pins 0 and 2 report matches, 1 and 3 follow events
    core_wr(`BTR_CTL_ADDR, 48'h0000_0000_0014);
    perf_event <= 4'hF;
    @(posedge sys_clk_i);
    #1 check(pin_n, 4'h5);
    low0 = 0;
    @(posedge sys_clk_i);
    bp_match <= 4'h5;
    @(posedge sys_clk_i);
    bp_match <= 4'h0;
    repeat (8) @(posedge sys_clk_i);
    check(low0, `BTR_PIN_PULSE);
    // step flag now clear: every retired instruction traps
    retire <= 1'b1;
    @(posedge sys_clk_i);
    retire <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check(steps, 2);
    report_and_stop();
  end
endmodule : btr_tb
